/* vsft_pkg.sv */
package vsft_pkg;

  // Clock period in picoseconds at 100 MHz.
  localparam int unsigned CLK_PERIOD_PS = 10000;

  // Valley time-out, 6.5 us nominal, given in nanoseconds.
  localparam int unsigned VALLEY_TIMEOUT_NS = 6500;
  localparam int unsigned VALLEY_TIMEOUT_CYC = VALLEY_TIMEOUT_NS * 1000 / CLK_PERIOD_PS;

  // Low-line blanking, 25 ms, given in milliseconds.
  localparam int unsigned LOW_LINE_BLANK_MS = 25;
  localparam int unsigned LOW_LINE_BLANK_CYC = LOW_LINE_BLANK_MS * 1000 * 100;

  // Auxiliary short timer, 90 ms.
  localparam int unsigned AUX_SHORT_MS = 90;
  localparam int unsigned AUX_SHORT_CYC = AUX_SHORT_MS * 1000 * 100;

  // Fault recovery delay, 4 s.
  localparam int unsigned RECOVERY_S = 4;
  localparam int unsigned RECOVERY_CYC = RECOVERY_S * 100000000;

  // Consecutive over-current periods that trip the winding-short fault.
  localparam logic [2:0] WIND_SHORT_COUNT = 3'h4;

  // Valley on which turn-on happens at full load in each line range.
  localparam logic [3:0] VALLEY_LOW_LINE = 4'h1;
  localparam logic [3:0] VALLEY_HIGH_LINE = 4'h2;

  // Blanking windows after turn-on, in cycles.
  localparam logic [5:0] LIMIT_BLANK_CYC = 6'h1e;
  localparam logic [5:0] SHORT_BLANK_CYC = 6'h08;

  // Dimming reference full-scale code.
  localparam logic [7:0] REF_FULL_SCALE = 8'hff;

  // Fault handling state.
  typedef enum logic [1:0] {
    VSFT_RUN,
    VSFT_RECOVER,
    VSFT_LATCHED
  } vsft_fault_e;

endpackage : vsft_pkg

/* vsft_timer.sv */
`timescale 1ns/1ps

// Saturating up-counter with a synchronous clear; flags when it reaches a limit.
module vsft_timer #(
  parameter int unsigned W = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [W-1:0] limit_i,
  output logic done_o
);

  logic [W-1:0] count_r;

  // Clear has priority so a restart never sees a stale count.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= '0;
    end else if (clear_i) begin
      count_r <= '0;
    end else if (run_i && (count_r < limit_i)) begin
      count_r <= count_r + 1'b1;
    end
  end

  assign done_o = (count_r >= limit_i);

endmodule : vsft_timer

/* vsft_dim_scale.sv */
`timescale 1ns/1ps

// Maps the dimming level to the current reference with three regions.
module vsft_dim_scale
  import vsft_pkg::*;
(
  input wire logic dim_below_lower_i,
  input wire logic dim_above_upper_i,
  input wire logic [7:0] dim_level_i,
  output logic [7:0] ref_o,
  output logic drive_inhibit_o
);

  // The analog level between thresholds is digitised outside as 0 to full scale.
  always_comb begin
    if (dim_below_lower_i) begin
      ref_o = 8'h00;
    end else if (dim_above_upper_i) begin
      ref_o = REF_FULL_SCALE;
    end else begin
      ref_o = dim_level_i;
    end
    drive_inhibit_o = dim_below_lower_i;
  end

endmodule : vsft_dim_scale

/* vsft_core.sv */
`timescale 1ns/1ps

module vsft_core
  import vsft_pkg::*;
#(
  parameter int unsigned VALLEY_TIMEOUT = VALLEY_TIMEOUT_CYC,
  parameter int unsigned LOW_LINE_BLANK = LOW_LINE_BLANK_CYC,
  parameter int unsigned AUX_SHORT = AUX_SHORT_CYC,
  parameter int unsigned RECOVERY = RECOVERY_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic valley_below_i,
  input wire logic aux_above_short_i,
  input wire logic line_below_low_i,
  input wire logic line_above_high_i,
  input wire logic dim_below_lower_i,
  input wire logic dim_above_upper_i,
  input wire logic [7:0] dim_level_i,
  input wire logic foldback_i,
  input wire logic [3:0] foldback_valleys_i,
  input wire logic setpoint_reached_i,
  input wire logic peak_limit_i,
  input wire logic cs_over_150_i,
  input wire logic latching_version_i,
  input wire logic supply_on_i,
  input wire logic supply_reset_i,
  output logic drive_o,
  output logic [7:0] current_reference_o,
  output logic comp_ground_o,
  output logic aux_short_fault_o,
  output logic winding_short_fault_o,
  output logic low_line_o,
  output logic valley_clock_o
);

  logic valley_below_d_r;
  logic valley_event;
  logic timeout_done;
  logic timeout_pulse;
  logic valley_clk;
  logic aux_done;
  logic low_blank_done;
  logic rec_done;
  logic [3:0] valley_cnt_r;
  logic [3:0] valley_target;
  logic [5:0] blank_cnt_r;
  logic [2:0] over_cnt_r;
  logic over_seen_r;
  logic [7:0] ref_nxt;
  logic dim_inhibit;
  logic fault_ok;
  logic turn_on;
  logic turn_off;
  logic wind_trip;
  vsft_fault_e fault_r;

  // Edge history for the valley comparator.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valley_below_d_r <= 1'b0;
    end else begin
      valley_below_d_r <= valley_below_i;
    end
  end

  assign valley_event = valley_below_i && !valley_below_d_r;

  vsft_timer #(.W(32)) u_timeout (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(valley_below_i),
    .clear_i(!valley_below_i || valley_clk),
    .limit_i(VALLEY_TIMEOUT),
    .done_o(timeout_done)
  );
  assign timeout_pulse = timeout_done && valley_below_i;

  assign valley_clk = valley_event || timeout_pulse;

  // aux short timer, cleared above 1 V or while a fault is held
  vsft_timer #(.W(32)) u_aux (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(fault_r == VSFT_RUN),
    .clear_i(aux_above_short_i || (fault_r != VSFT_RUN)),
    .limit_i(AUX_SHORT),
    .done_o(aux_done)
  );

  vsft_timer #(.W(32)) u_lowline (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(line_below_low_i),
    .clear_i(!line_below_low_i),
    .limit_i(LOW_LINE_BLANK),
    .done_o(low_blank_done)
  );

  // Line range; reset assumes high line, the safer choice of fewer switching events.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_line_o <= 1'b0;
    end else if (line_above_high_i) begin
      low_line_o <= 1'b0;
    end else if (low_blank_done) begin
      low_line_o <= 1'b1;
    end
  end

  vsft_timer #(.W(32)) u_recover (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(fault_r == VSFT_RECOVER),
    .clear_i(fault_r != VSFT_RECOVER),
    .limit_i(RECOVERY),
    .done_o(rec_done)
  );

  vsft_dim_scale u_dim (
    .dim_below_lower_i(dim_below_lower_i),
    .dim_above_upper_i(dim_above_upper_i),
    .dim_level_i(dim_level_i),
    .ref_o(ref_nxt),
    .drive_inhibit_o(dim_inhibit)
  );

  // Registered so the reference output comes straight from a flip-flop.

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      current_reference_o <= 8'h00;
    end else begin
      current_reference_o <= ref_nxt;
    end
  end

  always_comb begin
    if (foldback_i && (foldback_valleys_i > VALLEY_HIGH_LINE)) begin
      valley_target = foldback_valleys_i;
    end else if (low_line_o) begin
      valley_target = VALLEY_LOW_LINE;
    end else begin
      valley_target = VALLEY_HIGH_LINE;
    end
  end

  assign fault_ok = (fault_r == VSFT_RUN);
  // The count is widened so that a saturated count of fifteen still meets any target.
  assign turn_on = !drive_o && fault_ok && !dim_inhibit && valley_clk &&
                   (({1'b0, valley_cnt_r} + 5'h01) >= {1'b0, valley_target});
  // peak limit ends on-time only once the limit blanking has passed
  assign turn_off = drive_o && (setpoint_reached_i || !fault_ok || dim_inhibit ||
                    (peak_limit_i && (blank_cnt_r >= LIMIT_BLANK_CYC)));

  // valley counter cleared at turn-on and held at zero for the on-time
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valley_cnt_r <= 4'h0;
    end else if (drive_o) begin
      valley_cnt_r <= 4'h0;
    end else if (turn_on) begin
      valley_cnt_r <= 4'h0;
    end else if (valley_clk && (valley_cnt_r != 4'hf)) begin
      valley_cnt_r <= valley_cnt_r + 4'h1;
    end
  end

  // drive latch high only for the on-time
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_o <= 1'b0;
    end else if (turn_off) begin
      drive_o <= 1'b0;
    end else if (turn_on) begin
      drive_o <= 1'b1;
    end
  end

  // Blanking counter runs from the start of each on-time.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blank_cnt_r <= 6'h00;
    end else if (!drive_o) begin
      blank_cnt_r <= 6'h00;
    end else if (blank_cnt_r != 6'h3f) begin
      blank_cnt_r <= blank_cnt_r + 6'h01;
    end
  end

  // short blanking ends well before limit blanking
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      over_seen_r <= 1'b0;
      over_cnt_r <= 3'h0;
    end else if (!fault_ok) begin
      over_seen_r <= 1'b0;
      over_cnt_r <= 3'h0;
    end else if (turn_on) begin
      over_seen_r <= 1'b0;
      over_cnt_r <= over_seen_r ? over_cnt_r + 3'h1 : 3'h0;
    end else if (drive_o && cs_over_150_i && (blank_cnt_r >= SHORT_BLANK_CYC)) begin
      over_seen_r <= 1'b1;
    end
  end
  // The fourth over-current period trips as soon as it is seen.
  assign wind_trip = over_seen_r && (over_cnt_r >= (WIND_SHORT_COUNT - 3'h1));

  // auto-recovery, latching, aux short stops for 4 s
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_r <= VSFT_RUN;
    end else begin
      case (fault_r)
        VSFT_RUN: begin
          if (wind_trip && latching_version_i) begin
            fault_r <= VSFT_LATCHED;
          end else if (wind_trip || aux_done) begin
            fault_r <= VSFT_RECOVER;
          end
        end
        VSFT_RECOVER: begin
          if (rec_done && supply_on_i) begin
            fault_r <= VSFT_RUN;
          end
        end
        VSFT_LATCHED: begin
          if (supply_reset_i) begin
            fault_r <= VSFT_RUN;
          end
        end
        default: begin
          fault_r <= VSFT_RUN;
        end
      endcase
    end
  end

  // Fault flags and the compensation clamp are registered status.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_short_fault_o <= 1'b0;
      winding_short_fault_o <= 1'b0;
      comp_ground_o <= 1'b0;
      valley_clock_o <= 1'b0;
    end else begin
      if (fault_r == VSFT_RUN && aux_done) begin
        aux_short_fault_o <= 1'b1;
      end else if (fault_r == VSFT_RUN) begin
        aux_short_fault_o <= 1'b0;
      end
      if (fault_r == VSFT_RUN && wind_trip) begin
        winding_short_fault_o <= 1'b1;
      end else if (fault_r == VSFT_RUN) begin
        winding_short_fault_o <= 1'b0;
      end
      comp_ground_o <= (fault_r != VSFT_RUN) || (fault_r == VSFT_RUN && (aux_done || wind_trip));
      valley_clock_o <= valley_clk;
    end
  end

  // Drive never stands high after the first cycle of a held fault.
  no_drive_fault_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fault_r != VSFT_RUN) |=> !drive_o) else $error("drive high in fault");
  // A valley clock follows a falling crossing.
  valley_event_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (valley_below_i && !$past(valley_below_i)) |=> valley_clock_o) else $error("valley lost");
  // Dimming inhibit keeps drive low.
  dim_inhibit_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    dim_below_lower_i |=> !drive_o) else $error("drive while dimmed off");
  // High line comparator clears low line next cycle.
  high_line_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    line_above_high_i |=> !low_line_o) else $error("high line late");
  // Fault state grounds compensation.
  comp_ground_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fault_r != VSFT_RUN) |=> comp_ground_o) else $error("comp not grounded");
  // Latched fault stays until supply reset.
  latch_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (fault_r == VSFT_LATCHED && !supply_reset_i) |=> fault_r == VSFT_LATCHED)
    else $error("latch released");
  // Full reference above upper threshold.
  dim_full_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (dim_above_upper_i && !dim_below_lower_i) |=> current_reference_o == REF_FULL_SCALE)
    else $error("reference not full");
  // Peak limit after blanking ends drive next cycle.
  peak_limit_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (drive_o && peak_limit_i && blank_cnt_r >= LIMIT_BLANK_CYC) |=> !drive_o)
    else $error("on-time not ended");

endmodule : vsft_core

/* vsft_stage_model.sv */
`timescale 1ns/1ps

// Behavioural flyback stage: on-time ramp, demagnetisation, then drain ringing.
module vsft_stage_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic drive_i,
  input wire logic damped_i,
  input wire logic aux_short_i,
  input wire logic wshort_i,
  input wire logic [7:0] on_len_i,
  input wire logic [7:0] pk_len_i,
  output logic valley_below_o,
  output logic aux_above_o,
  output logic setpoint_o,
  output logic peak_o,
  output logic over150_o
);
  int on_cnt_r;
  int off_cnt_r;

  // Time since turn-on and since turn-off; each restarts on the opposite phase.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_cnt_r <= 0;
      off_cnt_r <= 0;
    end else if (drive_i) begin
      on_cnt_r <= on_cnt_r + 1;
      off_cnt_r <= 0;
    end else begin
      on_cnt_r <= 0;
      off_cnt_r <= off_cnt_r + 1;
    end
  end

  // Twenty cycles of demagnetisation, then a 16-cycle ring; a damped stage stays low.
  // A shorted auxiliary winding never lifts the sense pin at all.
  assign valley_below_o = aux_short_i |
    (!drive_i && off_cnt_r >= 20 && (damped_i || off_cnt_r[3]));
  assign aux_above_o = !aux_short_i && !drive_i && off_cnt_r < 20;
  // Current-sense comparators only see current while the switch conducts.
  assign setpoint_o = drive_i && on_cnt_r >= int'(on_len_i);
  // A shorted winding ramps the current steeply, past both thresholds within two cycles.
  assign peak_o = drive_i && (on_cnt_r >= int'(pk_len_i) || (wshort_i && on_cnt_r >= 2));
  assign over150_o = drive_i && wshort_i && on_cnt_r >= 2;
endmodule : vsft_stage_model

/* test_valley_select_fault_timer.sv */
`timescale 1ns/1ps

module test_valley_select_fault_timer;
  import vsft_pkg::*;
  // Short counts keep the run brief; expectations derive from these.
  localparam int unsigned TO = 40;
  localparam int unsigned LLB = 100;
  localparam int unsigned AUXS = 200;
  localparam int unsigned REC = 150;
  localparam int CEILING = 20000;
  typedef struct {logic below; logic above; logic [7:0] lvl; logic [7:0] ref_exp;} vsft_tb_dim_s;
  vsft_tb_dim_s rows [5] = '{'{1'h1, 1'h0, 8'h80, 8'h00}, '{1'h0, 1'h1, 8'h10, 8'hff},
    '{1'h0, 1'h0, 8'h00, 8'h00}, '{1'h0, 1'h0, 8'h40, 8'h40}, '{1'h0, 1'h0, 8'hc0, 8'hc0}};
  logic ref_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic line_below_low, line_above_high, dim_below_lower, dim_above_upper, foldback;
  logic latching, supply_on, supply_reset, damped, aux_short, wshort, pd;
  logic [7:0] dim_level, on_len, pk_len, cur_ref;
  logic [3:0] foldback_valleys;
  logic valley_below, aux_above, setpoint, peak, over150;
  logic drive, valley_clock, comp_ground, aux_fault, wind_fault, low_line;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  int vc, w, o, i, k, hc;

  always #5 ref_clk_i = ~ref_clk_i;

  vsft_core #(.VALLEY_TIMEOUT(TO), .LOW_LINE_BLANK(LLB), .AUX_SHORT(AUXS), .RECOVERY(REC)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .valley_below_i(valley_below),
    .aux_above_short_i(aux_above), .line_below_low_i(line_below_low),
    .line_above_high_i(line_above_high), .dim_below_lower_i(dim_below_lower),
    .dim_above_upper_i(dim_above_upper), .dim_level_i(dim_level), .foldback_i(foldback),
    .foldback_valleys_i(foldback_valleys), .setpoint_reached_i(setpoint), .peak_limit_i(peak),
    .cs_over_150_i(over150), .latching_version_i(latching), .supply_on_i(supply_on),
    .supply_reset_i(supply_reset), .drive_o(drive), .current_reference_o(cur_ref),
    .comp_ground_o(comp_ground), .aux_short_fault_o(aux_fault),
    .winding_short_fault_o(wind_fault), .low_line_o(low_line), .valley_clock_o(valley_clock));

  vsft_stage_model u_stage (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .drive_i(drive), .damped_i(damped),
    .aux_short_i(aux_short), .wshort_i(wshort), .on_len_i(on_len), .pk_len_i(pk_len),
    .valley_below_o(valley_below), .aux_above_o(aux_above), .setpoint_o(setpoint),
    .peak_o(peak), .over150_o(over150));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // Inputs change and outputs are read one nanosecond after each rising edge.
  task automatic tick;
    @(posedge ref_clk_i);
    #1;
  endtask : tick

  // Measures valley clocks and off time before a turn-on, then that pulse's width.
  task automatic sw_cycle(output int nv, output int wd, output int off);
    nv = 0;
    wd = 0;
    off = 0;
    while (drive !== 1'h1) tick();
    while (drive === 1'h1) tick();
    do begin
      tick();
      off++;
      if (valley_clock === 1'h1) nv++;
    end while (drive !== 1'h1);
    while (drive === 1'h1) begin
      wd++;
      tick();
    end
  endtask : sw_cycle

  // Cuts a hang short; the limit counts as a mismatch.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles >= CEILING) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    {line_below_low, line_above_high, dim_below_lower, foldback, latching} = '0;
    {supply_reset, damped, aux_short, wshort, pd} = '0;
    {supply_on, dim_above_upper} = 2'h3;
    dim_level = 8'h00;
    on_len = 8'h3c;
    pk_len = 8'hff;
    foldback_valleys = 4'h4;
    repeat (2) tick();
    check("reset outputs", {drive, valley_clock, comp_ground, aux_fault, wind_fault,
      low_line, cur_ref}, 32'h0);
    rst_n_i = 1'h1;
    // levels are held steady, so no dimming beat can meet the line ripple.
    for (i = 0; i < 5; i++) begin
      {dim_below_lower, dim_above_upper, dim_level} = {rows[i].below, rows[i].above, rows[i].lvl};
      repeat (3) tick();
      check("reference", cur_ref, rows[i].ref_exp);
    end
    {dim_below_lower, dim_above_upper} = 2'h1;
    // second valley at high line, count restarting every period.
    sw_cycle(vc, w, o);
    sw_cycle(vc, w, o);
    check("high line valleys", vc, 2);
    check("on width", w >= 60 && w <= 63, 1);
    // low line only after the blanking time.
    line_below_low = 1'h1;
    repeat (LLB - 5) tick();
    check("low line early", low_line, 0);
    repeat (10) tick();
    check("low line late", low_line, 1);
    sw_cycle(vc, w, o);
    check("low line valleys", vc, 1);
    foldback = 1'h1;
    sw_cycle(vc, w, o);
    sw_cycle(vc, w, o);
    check("foldback valleys", vc, 4);
    foldback = 1'h0;
    {line_below_low, line_above_high} = 2'h1;
    repeat (2) tick();
    check("high line", low_line, 0);
    line_above_high = 1'h0;
    // damped ringing: the time-out stands in for the second valley.
    damped = 1'h1;
    sw_cycle(vc, w, o);
    sw_cycle(vc, w, o);
    check("damped valleys", vc, 2);
    check("time-out off time", o >= TO + 18 && o <= TO + 26, 1);
    damped = 1'h0;
    pk_len = 8'h28;
    sw_cycle(vc, w, o);
    check("peak width", w >= 40 && w <= 43, 1);
    pk_len = 8'hff;
    // drive inhibited below the lower dimming threshold.
    dim_below_lower = 1'h1;
    k = 0;
    repeat (100) begin
      tick();
      if (drive !== 1'h0) k++;
    end
    check("inhibit", k, 0);
    dim_below_lower = 1'h0;
    // shorted sense pin trips, waits, then needs the supply.
    aux_short = 1'h1;
    i = 0;
    while (aux_fault !== 1'h1 && i < AUXS + 20) begin
      tick();
      i++;
    end
    check("aux fault time", i >= AUXS - 110 && i <= AUXS + 5, 1);
    check("comp ground", comp_ground, 1);
    supply_on = 1'h0;
    k = 0;
    repeat (REC + 20) begin
      tick();
      if (drive !== 1'h0 || comp_ground !== 1'h1) k++;
    end
    check("recovery hold", k, 0);
    {supply_on, aux_short} = 2'h2;
    i = 0;
    while (aux_fault !== 1'h0 && i < 30) begin
      tick();
      i++;
    end
    check("aux fault clear", aux_fault, 0);
    // four over-current periods; peak blanked longer than short check.
    for (o = 0; o < 2; o++) begin
      latching = o[0];
      sw_cycle(vc, w, i);
      wshort = 1'h1;
      {i, k, hc, w} = '0;
      pd = 1'h0;
      while (wind_fault !== 1'h1 && i < 1000) begin
        tick();
        i++;
        if (drive === 1'h1 && pd === 1'h0) begin
          k++;
          w = 0;
        end
        if (drive === 1'h1) begin
          hc++;
          w++;
        end
        pd = drive;
      end
      wshort = 1'h0;
      check("short periods", k, 4);
      // Earlier periods end at the limit blanking; the last ends soon after the short one.
      check("limit blanking", hc - w >= 3 * LIMIT_BLANK_CYC &&
        hc - w <= 3 * (LIMIT_BLANK_CYC + 3), 1);
      check("short blanking", w > SHORT_BLANK_CYC && w < LIMIT_BLANK_CYC, 1);
      repeat (REC + 30) tick();
      check("short fault after delay", wind_fault, o[0]);
      check("comp ground short", comp_ground, o[0]);
    end
    supply_reset = 1'h1;
    repeat (2) tick();
    supply_reset = 1'h0;
    repeat (10) tick();
    check("latch released", wind_fault, 0);
    latching = 1'h0;
    // Reset in mid-run clears every output without waiting for a clock edge.
    rst_n_i = 1'h0;
    #2;
    check("mid-run reset", {drive, valley_clock, comp_ground, aux_fault, wind_fault,
      low_line, cur_ref}, 32'h0);
    finish_test();
  end
endmodule : test_valley_select_fault_timer
